// ---- src/ult_pkg.sv ----
package ult_pkg;

   // Register offsets and reset values
   localparam logic [7:0] ULT_MISC_OFS = 8'h22;
   localparam logic [7:0] ULT_STAT_OFS = 8'h24;
   localparam logic [7:0] ULT_MISC_RST = 8'h04;
   localparam logic [7:0] ULT_STAT_RST = 8'h01;

   // Control register field positions
   localparam int ULT_TERM_BIT = 7;
   localparam int ULT_LP_IVL_HI = 6;
   localparam int ULT_LP_IVL_LO = 5;
   localparam int ULT_LP_OFF_BIT = 4;
   localparam int ULT_DN_IVL_HI = 3;
   localparam int ULT_DN_IVL_LO = 2;
   localparam int ULT_WARM_SKIP_BIT = 1;
   localparam int ULT_COMPL_OFF_BIT = 0;

   // Status register field positions
   localparam int ULT_LONG_BIT = 7;
   localparam int ULT_CM_BIT = 3;
   localparam int ULT_U0_BIT = 2;
   localparam int ULT_LPS_BIT = 1;
   localparam int ULT_DISC_BIT = 0;

   // Clock and millisecond prescale
   localparam int ULT_CLK_PERIOD_PS = 4000;
   localparam int ULT_MS_PS = 1000000000;
   localparam int ULT_CYC_PER_MS = ULT_MS_PS / ULT_CLK_PERIOD_PS;

   // Detection intervals in milliseconds
   localparam logic [7:0] ULT_LP_MS0 = 8'h30;
   localparam logic [7:0] ULT_LP_MS1 = 8'h54;
   localparam logic [7:0] ULT_LP_MS2 = 8'h78;
   localparam logic [7:0] ULT_LP_MS3 = 8'h9C;
   localparam logic [7:0] ULT_DN_MS0 = 8'h04;
   localparam logic [7:0] ULT_DN_MS1 = 8'h06;
   localparam logic [7:0] ULT_DN_MS2 = 8'h24;
   localparam logic [7:0] ULT_DN_MS3 = 8'h54;

   // Link state reported by the link state machine
   typedef enum logic [2:0] {
      ULT_LS_DISC = 3'b000,
      ULT_LS_RXDET = 3'b001,
      ULT_LS_POLL = 3'b010,
      ULT_LS_U0 = 3'b011,
      ULT_LS_U2 = 3'b100,
      ULT_LS_U3 = 3'b101,
      ULT_LS_COMPL = 3'b110,
      ULT_LS_INACT = 3'b111
   } ult_link_e;

   // Detection scheduler
   typedef enum logic [0:0] {
      ULT_DS_IDLE = 1'b0,
      ULT_DS_BUSY = 1'b1
   } ult_det_e;

   function automatic logic [7:0] ult_lp_ms(input logic [1:0] code);
      case (code)
         2'h0: ult_lp_ms = ULT_LP_MS0;
         2'h1: ult_lp_ms = ULT_LP_MS1;
         2'h2: ult_lp_ms = ULT_LP_MS2;
         default: ult_lp_ms = ULT_LP_MS3;
      endcase
   endfunction

   function automatic logic [7:0] ult_dn_ms(input logic [1:0] code);
      case (code)
         2'h0: ult_dn_ms = ULT_DN_MS0;
         2'h1: ult_dn_ms = ULT_DN_MS1;
         2'h2: ult_dn_ms = ULT_DN_MS2;
         default: ult_dn_ms = ULT_DN_MS3;
      endcase
   endfunction

endpackage

// ---- src/ult_tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Shared millisecond time base between prescaler and timers
interface ult_tick_if;
   logic ms_tick;
   modport src (output ms_tick);
   modport snk (input ms_tick);
endinterface
`default_nettype wire

// ---- src/ult_ms_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
module ult_ms_tick
   import ult_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = ULT_CYC_PER_MS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   ult_tick_if.src tick
);
   logic [17:0] cnt_r;
   logic [17:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   // Free-running prescaler, one pulse per millisecond
   always_comb begin
      cnt_nxt = cnt_r;
      tick_nxt = ce ? 1'b0 : tick_r; // A pending tick survives a freeze
      if (ce) begin
         if (cnt_r >= 18'(CYC_PER_MS - 1)) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 18'h00001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick.ms_tick = tick_r;

   AST_TICK_SPACING: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && tick_r) |=> !tick_r) else $error("millisecond tick lasted two cycles");
endmodule
`default_nettype wire

// ---- src/ult_detect_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module ult_detect_timer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic run,
   input wire logic [7:0] period_ms,
   ult_tick_if.snk tick,
   output logic fire
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic fire_r;
   logic fire_nxt;

   // Counts whole milliseconds while running; restarts on every stop
   always_comb begin
      cnt_nxt = cnt_r;
      fire_nxt = ce ? 1'b0 : fire_r; // Held while frozen so no expiry is lost
      if (ce) begin
         if (!run) begin
            cnt_nxt = '0;
         end else if (tick.ms_tick) begin
            if (cnt_r >= period_ms - 8'h01) begin
               cnt_nxt = '0;
               fire_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_r <= '0;
         fire_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         fire_r <= fire_nxt;
      end
   end

   assign fire = fire_r;

   // A full interval always ends in a fire
   AST_TMR_PERIOD: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && run && tick.ms_tick && cnt_r == period_ms - 8'h01) |=> fire && cnt_r == 8'h00)
      else $error("interval timer missed its period");
   AST_TMR_STOP: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && !run) |=> !fire) else $error("interval timer fired while stopped");
endmodule
`default_nettype wire

// ---- src/ult_link_track.sv ----
// Behaviour
// - Detection after warm reset or inactive entry: bit 0 keeps, 1 drops termination.
// - In U2/U3, repeat detection every 48, 84, 120 or 156 ms by code.
// - Low-power detect disable bit 1 skips detection in U2/U3.
// - Skip bit set and polling seen during warm reset: no detection follows.
// - Compliance off bit 1 disables compliance detection; 0 leaves it to FSM.
// - Fast adaptive EQ: flag 0 short, 1 long; adaptive EQ off reads 0.
// - Compliance flag reads 1 while channel is in compliance mode and compliance off bit is 0.
// - Active flag set when channel enters U0.
// - Low-power flag set when channel enters U2 or U3.
// - Disconnect flag set on entering disconnect; reads 1 after reset.
// - Fast mode means adaptive EQ on and mode select low bit 0.
`timescale 1ns/1ps
`default_nettype none
module ult_link_track
   import ult_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = ULT_CYC_PER_MS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] link_state,
   input wire logic warm_reset_end,
   input wire logic polling_in_warm_reset,
   input wire logic adaptive_eq_on,
   input wire logic [1:0] adaptive_eq_select,
   input wire logic long_channel_in,
   input wire logic rxdet_done,
   output logic rxdet_start,
   output logic term_release,
   output logic compliance_allow
);
   ult_link_e ls;
   ult_link_e ls_prev_r;
   ult_det_e det_r;
   ult_det_e det_nxt;
   logic [7:0] misc_r;
   logic [7:0] misc_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic long_r;
   logic long_nxt;
   logic cm_r;
   logic cm_nxt;
   logic u0_r;
   logic u0_nxt;
   logic lps_r;
   logic lps_nxt;
   logic disc_r;
   logic disc_nxt;
   logic start_r;
   logic start_nxt;
   logic term_r;
   logic term_nxt;
   logic in_low_power;
   logic in_idle_link;
   logic lp_run;
   logic dn_run;
   logic lp_fire;
   logic dn_fire;
   logic inact_entry;
   logic warm_skip;
   logic edge_trig;
   logic fast_eq;
   logic [7:0] status;

   assign ls = ult_link_e'(link_state);

   // Shared millisecond base; one prescaler serves both timers
   ult_tick_if tick_bus ();

   ult_ms_tick #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_ms_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .tick(tick_bus.src)
   );

   // Link state decode
   assign in_low_power = (ls == ULT_LS_U2) || (ls == ULT_LS_U3);
   assign in_idle_link = (ls == ULT_LS_DISC) || (ls == ULT_LS_RXDET);
   assign lp_run = in_low_power && !misc_r[ULT_LP_OFF_BIT] && (det_r == ULT_DS_IDLE);
   assign dn_run = in_idle_link && (det_r == ULT_DS_IDLE);
   assign inact_entry = (ls == ULT_LS_INACT) && (ls_prev_r != ULT_LS_INACT);
   assign warm_skip = misc_r[ULT_WARM_SKIP_BIT] && polling_in_warm_reset;
   assign edge_trig = (warm_reset_end && !warm_skip) || inact_entry;
   assign fast_eq = adaptive_eq_on && !adaptive_eq_select[0];

   // Low-power interval timer
   ult_detect_timer u_lp_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .run(lp_run),
      .period_ms(ult_lp_ms(misc_r[ULT_LP_IVL_HI:ULT_LP_IVL_LO])),
      .tick(tick_bus.snk),
      .fire(lp_fire)
   );

   // General downstream interval timer
   ult_detect_timer u_dn_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .run(dn_run),
      .period_ms(ult_dn_ms(misc_r[ULT_DN_IVL_HI:ULT_DN_IVL_LO])),
      .tick(tick_bus.snk),
      .fire(dn_fire)
   );

   // Detection scheduler; edge triggers outrank periodic ones
   always_comb begin
      det_nxt = det_r;
      start_nxt = ce ? 1'b0 : start_r; // A frozen pulse stays put
      term_nxt = term_r;
      case (det_r)
         ULT_DS_IDLE: begin
            if (ce && edge_trig) begin
               det_nxt = ULT_DS_BUSY;
               start_nxt = 1'b1;
               term_nxt = misc_r[ULT_TERM_BIT];
            end else if (ce && (lp_fire || dn_fire)) begin
               det_nxt = ULT_DS_BUSY;
               start_nxt = 1'b1;
               term_nxt = 1'b0;
            end
         end
         ULT_DS_BUSY: begin
            if (ce && rxdet_done) begin
               det_nxt = ULT_DS_IDLE;
               term_nxt = 1'b0;
            end
         end
         default: begin
            det_nxt = ULT_DS_IDLE;
            term_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         det_r <= ULT_DS_IDLE;
         start_r <= 1'b0;
         term_r <= 1'b0;
         ls_prev_r <= ULT_LS_DISC;
      end else begin
         det_r <= det_nxt;
         start_r <= start_nxt;
         term_r <= term_nxt;
         if (ce) begin
            ls_prev_r <= ls;
         end
      end
   end

   // Status flags follow the link machine and EQ inputs; bus writes reach only the compliance flag, via the compliance off bit
   always_comb begin
      long_nxt = long_r;
      cm_nxt = cm_r;
      u0_nxt = u0_r;
      lps_nxt = lps_r;
      disc_nxt = disc_r;
      if (ce) begin
         long_nxt = fast_eq ? long_channel_in : 1'b0;
         cm_nxt = (ls == ULT_LS_COMPL) && !misc_r[ULT_COMPL_OFF_BIT];
         u0_nxt = (ls == ULT_LS_U0);
         lps_nxt = in_low_power;
         disc_nxt = (ls == ULT_LS_DISC);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         long_r <= ULT_STAT_RST[ULT_LONG_BIT];
         cm_r <= ULT_STAT_RST[ULT_CM_BIT];
         u0_r <= ULT_STAT_RST[ULT_U0_BIT];
         lps_r <= ULT_STAT_RST[ULT_LPS_BIT];
         disc_r <= ULT_STAT_RST[ULT_DISC_BIT];
      end else begin
         long_r <= long_nxt;
         cm_r <= cm_nxt;
         u0_r <= u0_nxt;
         lps_r <= lps_nxt;
         disc_r <= disc_nxt;
      end
   end

   // Status image; reserved bits read zero
   always_comb begin
      status = 8'h00;
      status[ULT_LONG_BIT] = long_r;
      status[ULT_CM_BIT] = cm_r;
      status[ULT_U0_BIT] = u0_r;
      status[ULT_LPS_BIT] = lps_r;
      status[ULT_DISC_BIT] = disc_r;
   end

   // Register port; status offset is read-only so writes there drop
   always_comb begin
      misc_nxt = misc_r;
      rdata_nxt = rdata_r;
      if (ce && reg_wr && reg_addr == ULT_MISC_OFS) begin
         misc_nxt = reg_wdata;
      end
      if (ce && reg_rd) begin
         case (reg_addr)
            ULT_MISC_OFS: rdata_nxt = misc_r;
            ULT_STAT_OFS: rdata_nxt = status;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         misc_r <= ULT_MISC_RST;
         rdata_r <= 8'h00;
      end else begin
         misc_r <= misc_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign rxdet_start = start_r;
   assign term_release = term_r;
   assign compliance_allow = !misc_r[ULT_COMPL_OFF_BIT];

   // Checks
   AST_TERM_SETTING: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && det_r == ULT_DS_IDLE && edge_trig) |=>
         rxdet_start && term_release == $past(misc_r[ULT_TERM_BIT]))
      else $error("termination not set per control bit on edge detection");
   AST_DONE_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && det_r == ULT_DS_BUSY && rxdet_done) |=> !term_release && det_r == ULT_DS_IDLE)
      else $error("termination not restored after detection");
   AST_LP_PERIOD: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && lp_fire && det_r == ULT_DS_IDLE && !edge_trig) |=> rxdet_start && !term_release)
      else $error("low-power interval expiry did not start detection");
   // A fire needs a running timer one cycle earlier, hence the past term
   AST_LP_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      (misc_r[ULT_LP_OFF_BIT] && in_low_power
         && $past(misc_r[ULT_LP_OFF_BIT] && in_low_power)) |-> !lp_fire)
      else $error("low-power detection ran while disabled");
   AST_DN_RESET: assert property (@(posedge sys_clk)
      rst |=> misc_r[ULT_DN_IVL_HI:ULT_DN_IVL_LO] == 2'h1 && disc_r)
      else $error("control or disconnect flag wrong after reset");
   AST_DN_PERIOD: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && dn_fire && det_r == ULT_DS_IDLE && !edge_trig) |=> rxdet_start && !term_release)
      else $error("general interval expiry did not start detection");
   AST_START_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && rxdet_start) |=> !rxdet_start)
      else $error("detection start lasted two cycles");
   AST_WARM_SKIP: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && det_r == ULT_DS_IDLE && warm_reset_end && warm_skip && !inact_entry && !lp_fire
         && !dn_fire) |=> !rxdet_start)
      else $error("detection ran after skipped warm reset");
   // Output follows the bit at once, the flag one cycle later
   AST_COMPL_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && misc_r[ULT_COMPL_OFF_BIT]) |-> !compliance_allow ##1 !cm_r)
      else $error("compliance seen while disabled");
   AST_LONG_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
      ce |=> long_r == ($past(fast_eq) && $past(long_channel_in)))
      else $error("long channel flag wrong");
   AST_EQ_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && !adaptive_eq_on) |=> !long_r)
      else $error("long channel flag set with adaptive EQ off");
   AST_FAST_MODE: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && adaptive_eq_select[0]) |=> !long_r)
      else $error("long flag set outside fast mode");
   AST_CM_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && ls == ULT_LS_COMPL && !misc_r[ULT_COMPL_OFF_BIT]) |=> cm_r)
      else $error("compliance flag missing");
   AST_U0_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && ls == ULT_LS_U0) |=> u0_r && !lps_r && !disc_r)
      else $error("active flag missing");
   AST_LPS_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && in_low_power) |=> lps_r && !u0_r)
      else $error("low-power flag missing");
   AST_DISC_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && ls == ULT_LS_DISC) |=> disc_r)
      else $error("disconnect flag missing");
   // A write to the status offset leaves the flags on the link state alone
   AST_STAT_RO: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && reg_wr && reg_addr == ULT_STAT_OFS) |=>
         u0_r == $past(ls == ULT_LS_U0) && lps_r == $past(in_low_power)
         && disc_r == $past(ls == ULT_LS_DISC))
      else $error("status changed by a write");
   AST_FREEZE: assert property (@(posedge sys_clk) disable iff (rst)
      !ce |=> $stable(misc_r) && $stable(det_r) && $stable(status) && $stable(rxdet_start)
         && $stable(reg_rdata))
      else $error("state moved while clock enable low");

   COV_LP_DETECT: cover property (@(posedge sys_clk) disable iff (rst)
      lp_fire ##1 rxdet_start);
   COV_WARM_TERM: cover property (@(posedge sys_clk) disable iff (rst)
      warm_reset_end ##1 term_release);
   COV_LONG: cover property (@(posedge sys_clk) disable iff (rst) long_r);
   COV_DN_DETECT: cover property (@(posedge sys_clk) disable iff (rst)
      dn_fire ##1 rxdet_start);
endmodule
`default_nettype wire

// ---- bench/ult_far_rx.sv ----
`timescale 1ns/1ps
`default_nettype none
// Link partner behind the connector: ends each detection it is asked for
module ult_far_rx (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic rxdet_start,
   input wire logic slow,
   output logic rxdet_done
);
   int cnt_r;
   // Short or long settling time, never a done without a start
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_r <= 0;
         rxdet_done <= 1'b0;
      end else begin
         rxdet_done <= (cnt_r == 1);
         if (rxdet_start) begin
            cnt_r <= slow ? 30 : 3;
         end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- bench/tb_usb3_link_rxdet_status.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_usb3_link_rxdet_status;
   import ult_pkg::*;
   localparam int CPM = 10;
   typedef struct {
      logic [2:0] ls;
      logic aeq;
      logic [1:0] sel;
      logic lng;
      logic [7:0] exp;
   } ult_row_s;
   logic sys_clk, rst, ce, reg_wr, reg_rd, warm_reset_end, polling_in_warm_reset;
   logic adaptive_eq_on, long_channel_in, rxdet_done, rxdet_start, term_release;
   logic compliance_allow, slow;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [2:0] link_state;
   logic [1:0] adaptive_eq_select;
   int mismatches, checked, n;
   int dn_ms[4] = '{4, 6, 36, 84};
   int lp_ms[4] = '{48, 84, 120, 156};
   // Link state, EQ inputs and the status byte they must give
   ult_row_s rows[8] = '{
      '{3'h0, 1'b0, 2'h0, 1'b1, 8'h01},
      '{3'h1, 1'b1, 2'h0, 1'b0, 8'h00},
      '{3'h3, 1'b1, 2'h0, 1'b1, 8'h84},
      '{3'h3, 1'b1, 2'h1, 1'b1, 8'h04},
      '{3'h4, 1'b1, 2'h2, 1'b0, 8'h02},
      '{3'h5, 1'b1, 2'h2, 1'b1, 8'h82},
      '{3'h6, 1'b0, 2'h0, 1'b1, 8'h08},
      '{3'h2, 1'b0, 2'h0, 1'b0, 8'h00}
   };

   ult_link_track #(.CYC_PER_MS(CPM)) u_ult_link_track (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .link_state(link_state), .warm_reset_end(warm_reset_end),
      .polling_in_warm_reset(polling_in_warm_reset), .adaptive_eq_on(adaptive_eq_on),
      .adaptive_eq_select(adaptive_eq_select), .long_channel_in(long_channel_in),
      .rxdet_done(rxdet_done), .rxdet_start(rxdet_start), .term_release(term_release),
      .compliance_allow(compliance_allow)
   );

   ult_far_rx u_ult_far_rx (
      .sys_clk(sys_clk), .rst(rst), .rxdet_start(rxdet_start), .slow(slow),
      .rxdet_done(rxdet_done)
   );

   // Clock, 4 ns period
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Every drive lands 1 ns after a rising edge
   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   // Idle cycle after the strobe keeps back-to-back calls clean
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      step(1);
      reg_wr = 1'b0;
      step(1);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr = a;
      reg_rd = 1'b1;
      step(1);
      reg_rd = 1'b0;
      step(1);
      v = reg_rdata;
   endtask

   // Start is a one-cycle pulse, so every cycle is looked at
   task automatic wait_start(input int lim, output int k);
      k = 0;
      while (rxdet_start !== 1'b1 && k < lim) begin
         step(1);
         k++;
      end
   endtask

   // Spacing of two periodic starts; slack covers busy time and tick phase
   task automatic ivl(input logic [7:0] ctrl, input logic [2:0] ls, input int ms);
      int k;
      wr(ULT_MISC_OFS, ctrl);
      link_state = ls;
      wait_start(2000, k);
      step(1);
      wait_start(2000, k);
      chk("interval", (k + 1 >= ms * CPM) && (k + 1 <= ms * CPM + CPM + 8), 1);
   endtask

   task automatic edge_det(input logic [7:0] ctrl, input logic pol, input logic es,
                           input logic et);
      int k;
      wr(ULT_MISC_OFS, ctrl);
      polling_in_warm_reset = pol;
      warm_reset_end = 1'b1;
      step(1);
      warm_reset_end = 1'b0;
      wait_start(3, k);
      chk("start", k < 3, es);
      if (k < 3) chk("term", term_release, et);
      step(40);
   endtask

   task automatic end_of_test;
      $display("Checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog, well beyond the roughly 12k cycles of the sequence
   initial begin
      #200000;
      mismatches++;
      end_of_test;
   end

   initial begin
      {rst, ce, reg_wr, reg_rd, warm_reset_end, polling_in_warm_reset} = 6'h30;
      {adaptive_eq_on, long_channel_in, slow} = 3'h0;
      {reg_addr, reg_wdata, adaptive_eq_select} = 18'h00000;
      link_state = ULT_LS_DISC;
      step(3);
      rst = 1'b0;
      chk("allow", compliance_allow, 1'b1);
      rd(ULT_MISC_OFS, d);
      chk("misc", d, 8'h04);
      rd(ULT_STAT_OFS, d);
      chk("stat", d, 8'h01);
      // Status byte per link state and EQ choice
      foreach (rows[i]) begin
         link_state = rows[i].ls;
         adaptive_eq_on = rows[i].aeq;
         adaptive_eq_select = rows[i].sel;
         long_channel_in = rows[i].lng;
         step(2);
         rd(ULT_STAT_OFS, d);
         chk("status", d, rows[i].exp);
      end
      wr(ULT_STAT_OFS, 8'hFF);
      rd(ULT_STAT_OFS, d);
      chk("status_wr", d, 8'h00);
      wr(ULT_MISC_OFS, 8'h01);
      chk("allow", compliance_allow, 1'b0);
      // Compliance state with detection off must not raise the flag
      link_state = ULT_LS_COMPL;
      step(2);
      rd(ULT_STAT_OFS, d);
      chk("compl_off", d, 8'h00);
      link_state = ULT_LS_POLL;
      ce = 1'b0;
      wr(ULT_MISC_OFS, 8'h00);
      ce = 1'b1;
      rd(ULT_MISC_OFS, d);
      chk("misc_ce", d, 8'h01);
      rd(8'h30, d);
      chk("unmapped", d, 8'h00);
      wr(ULT_MISC_OFS, 8'h00);
      chk("allow", compliance_allow, 1'b1);
      // Edge-started detections with termination and skip settings
      edge_det(8'h80, 1'b0, 1'b1, 1'b1);
      edge_det(8'h00, 1'b0, 1'b1, 1'b0);
      edge_det(8'h02, 1'b1, 1'b0, 1'b0);
      edge_det(8'h02, 1'b0, 1'b1, 1'b0);
      wr(ULT_MISC_OFS, 8'h80);
      link_state = ULT_LS_INACT;
      wait_start(3, n);
      chk("inact_start", n < 3, 1);
      chk("inact_term", term_release, 1'b1);
      step(40);
      link_state = ULT_LS_POLL;
      // Slow partner: termination stays off until its answer
      slow = 1'b1;
      warm_reset_end = 1'b1;
      step(1);
      warm_reset_end = 1'b0;
      wait_start(3, n);
      step(20);
      chk("term_hold", term_release, 1'b1);
      step(20);
      chk("term_end", term_release, 1'b0);
      slow = 1'b0;
      // Periodic intervals, every code of both fields
      for (int c = 0; c < 4; c++) ivl({4'h0, c[1:0], 2'h0}, ULT_LS_DISC, dn_ms[c]);
      for (int c = 0; c < 4; c++) ivl({1'b0, c[1:0], 5'h00}, ULT_LS_U2, lp_ms[c]);
      wr(ULT_MISC_OFS, 8'h10);
      link_state = ULT_LS_U3;
      wait_start(600, n);
      chk("lp_off", n, 600);
      // Reset in mid-detection: termination back, defaults restored
      wr(ULT_MISC_OFS, 8'h90);
      slow = 1'b1;
      warm_reset_end = 1'b1;
      step(1);
      warm_reset_end = 1'b0;
      step(5);
      chk("term_pre", term_release, 1'b1);
      rst = 1'b1;
      step(3);
      rst = 1'b0;
      chk("term_rst", term_release, 1'b0);
      chk("start_rst", rxdet_start, 1'b0);
      rd(ULT_STAT_OFS, d);
      chk("stat_rst", d, 8'h01);
      rd(ULT_MISC_OFS, d);
      chk("misc_rst", d, 8'h04);
      slow = 1'b0;
      end_of_test;
   end
endmodule
`default_nettype wire
